//--- rtl/sbsi_params.svh
// Constants of the SRAM boundary-scan test port
`ifndef SBSI_PARAMS_SVH
`define SBSI_PARAMS_SVH

// Instruction register width and codes, hex, MSB left
`define SBSI_IR_W 3
`define SBSI_IR_EXTEST 3'h0
`define SBSI_IR_IDCODE 3'h1
`define SBSI_IR_SAMPLEZ 3'h2
`define SBSI_IR_SAMPLE 3'h4
`define SBSI_IR_BYPASS 3'h7
`define SBSI_IR_CAPTURE 3'h1

// Identification register, value arbitrary, bit 0 set
`define SBSI_ID_W 32
`define SBSI_ID_CODE 32'h0000_0a5b

// Boundary register layout: inputs, outputs, fixed cells
`define SBSI_NIN 8
`define SBSI_NOUT 4
`define SBSI_NFIX 2
`define SBSI_RING_W 12
`define SBSI_BSR_LEN 14
`define SBSI_OUT_LSB 8
`define SBSI_OUT_MSB 11
`define SBSI_FIX_LSB 12
`define SBSI_FIX_VAL 2'h3

`endif

//--- rtl/sbsi_pkg.sv
// Types of the SRAM boundary-scan test port
`include "sbsi_params.svh"
package sbsi_pkg;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UP_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UP_IR
	} sbsi_tap_e;
	typedef logic [`SBSI_IR_W-1:0] sbsi_ir_t;
endpackage

//--- rtl/sbsi_scan_top.sv
// Boundary-scan instruction execution of a synchronous SRAM
`timescale 1ns/10ps
`default_nettype none
`include "sbsi_params.svh"
module sbsi_scan_top (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Test link
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoEn,
	// RAM pin ring
	input wire logic [`SBSI_NIN-1:0] ramInPins,
	input wire logic [`SBSI_NOUT-1:0] funcQ,
	input wire logic funcQEn,
	output logic [`SBSI_NOUT-1:0] ramQ,
	output logic ramQEn
);

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic isBsrInstr(input logic [`SBSI_IR_W-1:0] ir);
		return (ir == `SBSI_IR_EXTEST) || (ir == `SBSI_IR_SAMPLE) || (ir == `SBSI_IR_SAMPLEZ);
	endfunction

	// ****************************************
	// Reset release
	// ****************************************
	logic sysRstMeta_r;
	logic sysRstN_r;
	logic tckRstMeta_r;
	logic tckRstN_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sysRstMeta_r <= 1'b0;
			sysRstN_r <= 1'b0;
		end else begin
			sysRstMeta_r <= 1'b1;
			sysRstN_r <= sysRstMeta_r;
		end
	end

	always_ff @(posedge tck or negedge arst_n) begin
		if (!arst_n) begin
			tckRstMeta_r <= 1'b0;
			tckRstN_r <= 1'b0;
		end else begin
			tckRstMeta_r <= 1'b1;
			tckRstN_r <= tckRstMeta_r;
		end
	end

	// ****************************************
	// Controller
	// ****************************************
	sbsi_pkg::sbsi_tap_e tapState;

	sbsi_tap_fsm uFsm (
		.tck(tck),
		.rstN(tckRstN_r),
		.tms(tms),
		.state(tapState)
	);

	wire stTlr = tapState == sbsi_pkg::TAP_RESET;
	wire stCapIr = tapState == sbsi_pkg::TAP_CAP_IR;
	wire stShIr = tapState == sbsi_pkg::TAP_SH_IR;
	wire stUpIr = tapState == sbsi_pkg::TAP_UP_IR;
	wire stCapDr = tapState == sbsi_pkg::TAP_CAP_DR;
	wire stShDr = tapState == sbsi_pkg::TAP_SH_DR;
	wire stUpDr = tapState == sbsi_pkg::TAP_UP_DR;

	// ****************************************
	// Instruction register
	// ****************************************
	logic [`SBSI_IR_W-1:0] irShift_r;
	sbsi_pkg::sbsi_ir_t activeIr_r;

	always_ff @(posedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			irShift_r <= `SBSI_IR_CAPTURE;
		end else if (stCapIr) begin
			irShift_r <= `SBSI_IR_CAPTURE;
		end else if (stShIr) begin
			irShift_r <= {tdi, irShift_r[`SBSI_IR_W-1:1]};
		end
	end

	always_ff @(negedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			activeIr_r <= `SBSI_IR_IDCODE;
		end else if (stTlr) begin
			activeIr_r <= `SBSI_IR_IDCODE;
		end else if (stUpIr) begin
			activeIr_r <= irShift_r;
		end
	end

	// ****************************************
	// Instruction decode
	// ****************************************
	// all zeros is extest
	wire selBsr = isBsrInstr(activeIr_r);
	wire selId = activeIr_r == `SBSI_IR_IDCODE;
	wire selByp = !selBsr && !selId;
	wire [`SBSI_IR_W-1:0] irEff = stTlr ? `SBSI_IR_IDCODE : (stUpIr ? irShift_r : activeIr_r);
	wire effDrive = irEff == `SBSI_IR_EXTEST;
	wire effFloat = irEff == `SBSI_IR_SAMPLEZ;

	// ****************************************
	// Pin ring sampling
	// ****************************************
	logic [`SBSI_NOUT-1:0] ramQ_r;
	logic [`SBSI_RING_W-1:0] ringMeta_r;
	logic [`SBSI_RING_W-1:0] ringSync_r;

	always_ff @(posedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			ringMeta_r <= '0;
			ringSync_r <= '0;
		end else begin
			ringMeta_r <= {ramQ_r, ramInPins};
			ringSync_r <= ringMeta_r;
		end
	end

	wire [`SBSI_BSR_LEN-1:0] captureWord = {`SBSI_FIX_VAL, ringSync_r};

	// ****************************************
	// Data registers
	// ****************************************
	logic bypass_r;
	logic [`SBSI_ID_W-1:0] idShift_r;
	logic [`SBSI_BSR_LEN-1:0] bsrShift_r;

	always_ff @(posedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			bypass_r <= 1'b0;
		end else if (stCapDr && selByp) begin
			bypass_r <= 1'b0;
		end else if (stShDr && selByp) begin
			bypass_r <= tdi;
		end
	end

	always_ff @(posedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			idShift_r <= `SBSI_ID_CODE;
		end else if (stCapDr && selId) begin
			idShift_r <= `SBSI_ID_CODE;
		end else if (stShDr && selId) begin
			idShift_r <= {tdi, idShift_r[`SBSI_ID_W-1:1]};
		end
	end

	always_ff @(posedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			bsrShift_r <= '0;
		end else if (stCapDr && selBsr) begin
			bsrShift_r <= captureWord;
		end else if (stShDr && selBsr) begin
			bsrShift_r <= {tdi, bsrShift_r[`SBSI_BSR_LEN-1:1]};
		end
	end

	// ****************************************
	// Serial output
	// ****************************************
	logic tdo_r;
	logic tdoEn_r;

	wire drBit = selBsr ? bsrShift_r[0] : (selId ? idShift_r[0] : bypass_r);
	wire tdoNxt = stShIr ? irShift_r[0] : drBit;

	always_ff @(negedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			tdo_r <= 1'b0;
			tdoEn_r <= 1'b0;
		end else begin
			tdo_r <= tdoNxt;
			tdoEn_r <= stShIr || stShDr;
		end
	end

	assign tdo = tdo_r;
	assign tdoEn = tdoEn_r;

	// ****************************************
	// Drive control toward RAM domain
	// ****************************************
	logic [`SBSI_NOUT-1:0] xferData_r;
	logic xferDrive_r;
	logic xferFloat_r;
	logic xferTgl_r;

	wire xferLoad = stUpIr || stUpDr || (stTlr && (xferDrive_r || xferFloat_r));
	wire [`SBSI_NOUT-1:0] xferDataNxt = (stUpDr && selBsr) ? bsrShift_r[`SBSI_OUT_MSB:`SBSI_OUT_LSB] : xferData_r;

	always_ff @(negedge tck or negedge tckRstN_r) begin
		if (!tckRstN_r) begin
			xferData_r <= '0;
			xferDrive_r <= 1'b0;
			xferFloat_r <= 1'b0;
			xferTgl_r <= 1'b0;
		end else if (xferLoad) begin
			xferData_r <= xferDataNxt;
			xferDrive_r <= effDrive;
			xferFloat_r <= effFloat;
			xferTgl_r <= ~xferTgl_r;
		end
	end

	// ****************************************
	// RAM domain
	// ****************************************
	logic tglMeta_r;
	logic tglSync_r;
	logic tglSeen_r;
	logic [`SBSI_NOUT-1:0] ramTestData_r;
	logic ramTestDrive_r;
	logic ramFloat_r;
	logic ramQEn_r;

	wire tglEdge = tglSync_r ^ tglSeen_r;

	always_ff @(posedge sys_clk or negedge sysRstN_r) begin
		if (!sysRstN_r) begin
			tglMeta_r <= 1'b0;
			tglSync_r <= 1'b0;
			tglSeen_r <= 1'b0;
		end else begin
			tglMeta_r <= xferTgl_r;
			tglSync_r <= tglMeta_r;
			tglSeen_r <= tglSync_r;
		end
	end

	always_ff @(posedge sys_clk or negedge sysRstN_r) begin
		if (!sysRstN_r) begin
			ramTestData_r <= '0;
			ramTestDrive_r <= 1'b0;
			ramFloat_r <= 1'b0;
		end else if (tglEdge) begin
			ramTestData_r <= xferData_r;
			ramTestDrive_r <= xferDrive_r;
			ramFloat_r <= xferFloat_r;
		end
	end

	always_ff @(posedge sys_clk or negedge sysRstN_r) begin
		if (!sysRstN_r) begin
			ramQ_r <= '0;
			ramQEn_r <= 1'b0;
		end else begin
			ramQ_r <= ramTestDrive_r ? ramTestData_r : funcQ;
			ramQEn_r <= !ramFloat_r && (ramTestDrive_r || funcQEn);
		end
	end

	assign ramQ = ramQ_r;
	assign ramQEn = ramQEn_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge tck);
	endclocking
	default disable iff (!tckRstN_r);
	a_bypass_path: assert property ((stShDr && selByp) |-> tdoEn ##1 (bypass_r == $past(tdi)))
		else $error("bypass register did not take TDI");
	a_sample_capture: assert property ((stCapDr && activeIr_r == `SBSI_IR_SAMPLE)
		|=> bsrShift_r[`SBSI_RING_W-1:0] == $past(ringSync_r))
		else $error("sample capture missed the pin ring");
	a_fixed_cells: assert property ((stCapDr && isBsrInstr(activeIr_r))
		|=> bsrShift_r[`SBSI_BSR_LEN-1:`SBSI_FIX_LSB] == `SBSI_FIX_VAL)
		else $error("unbound cells not at default");
	a_bsr_shift: assert property ((stShDr && selBsr)
		|=> bsrShift_r == {$past(tdi), $past(bsrShift_r[`SBSI_BSR_LEN-1:1])})
		else $error("boundary register did not shift");
	a_extest_decode: assert property ((stUpIr && irShift_r == `SBSI_IR_EXTEST)
		|=> xferDrive_r && activeIr_r == `SBSI_IR_EXTEST)
		else $error("all-zero code not taken as extest");
	a_extest_drive: assert property (@(posedge sys_clk) disable iff (!sysRstN_r)
		ramTestDrive_r |=> ramQ_r == $past(ramTestData_r) && ramQEn_r)
		else $error("extest did not drive the outputs");
	a_func_path: assert property (@(posedge sys_clk) disable iff (!sysRstN_r)
		(!ramTestDrive_r && !ramFloat_r) |=> ramQ_r == $past(funcQ))
		else $error("functional path blocked");
	a_extest_capture: assert property ((stCapDr && activeIr_r == `SBSI_IR_EXTEST)
		|=> bsrShift_r[`SBSI_OUT_MSB:`SBSI_OUT_LSB] == $past(ringSync_r[`SBSI_RING_W-1:`SBSI_NIN]))
		else $error("output cells not captured");
	a_id_capture: assert property ((stCapDr && selId) |=> idShift_r == `SBSI_ID_CODE)
		else $error("ID value not loaded");
	a_reset_idcode: assert property (stTlr |=> activeIr_r == `SBSI_IR_IDCODE)
		else $error("instruction not idcode after reset");
	a_float_out: assert property (@(posedge sys_clk) disable iff (!sysRstN_r)
		ramFloat_r |=> !ramQEn_r)
		else $error("outputs not floated");
	a_ir_shift: assert property (stShIr |=> irShift_r == {$past(tdi), $past(irShift_r[`SBSI_IR_W-1:1])})
		else $error("instruction register did not shift");
	a_ir_capture: assert property (stCapIr |=> irShift_r[1:0] == 2'h1)
		else $error("capture pattern not 01");
	a_tms_reset: assert property (tms [*5] |=> stTlr)
		else $error("five TMS ones did not reset");
	a_id_order: assert property ((stShDr && selId) |=> ##0 1'b1 ##0 (tdo == $past(idShift_r[1]) || !stShDr))
		else $error("ID bit order wrong");

	c_id_read: cover property (stCapDr && selId ##1 stShDr);
	c_extest_load: cover property (stUpIr && irShift_r == `SBSI_IR_EXTEST);
	c_bypass_shift: cover property (stShDr && activeIr_r == `SBSI_IR_BYPASS);
	c_float: cover property (@(posedge sys_clk) disable iff (!sysRstN_r) ramFloat_r);

endmodule // sbsi_scan_top
`default_nettype wire

//--- rtl/sbsi_tap_fsm.sv
// Test access port controller state machine
`timescale 1ns/10ps
`default_nettype none
module sbsi_tap_fsm (
	// Link clock and reset
	input wire logic tck,
	input wire logic rstN,
	// Mode select
	input wire logic tms,
	// Controller state
	output var sbsi_pkg::sbsi_tap_e state
);
	sbsi_pkg::sbsi_tap_e state_r;
	sbsi_pkg::sbsi_tap_e state_nxt;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sbsi_pkg::TAP_RESET: state_nxt = tms ? sbsi_pkg::TAP_RESET : sbsi_pkg::TAP_IDLE;
			sbsi_pkg::TAP_IDLE: state_nxt = tms ? sbsi_pkg::TAP_SEL_DR : sbsi_pkg::TAP_IDLE;
			sbsi_pkg::TAP_SEL_DR: state_nxt = tms ? sbsi_pkg::TAP_SEL_IR : sbsi_pkg::TAP_CAP_DR;
			sbsi_pkg::TAP_CAP_DR: state_nxt = tms ? sbsi_pkg::TAP_EX1_DR : sbsi_pkg::TAP_SH_DR;
			sbsi_pkg::TAP_SH_DR: state_nxt = tms ? sbsi_pkg::TAP_EX1_DR : sbsi_pkg::TAP_SH_DR;
			sbsi_pkg::TAP_EX1_DR: state_nxt = tms ? sbsi_pkg::TAP_UP_DR : sbsi_pkg::TAP_PAU_DR;
			sbsi_pkg::TAP_PAU_DR: state_nxt = tms ? sbsi_pkg::TAP_EX2_DR : sbsi_pkg::TAP_PAU_DR;
			sbsi_pkg::TAP_EX2_DR: state_nxt = tms ? sbsi_pkg::TAP_UP_DR : sbsi_pkg::TAP_SH_DR;
			sbsi_pkg::TAP_UP_DR: state_nxt = tms ? sbsi_pkg::TAP_SEL_DR : sbsi_pkg::TAP_IDLE;
			sbsi_pkg::TAP_SEL_IR: state_nxt = tms ? sbsi_pkg::TAP_RESET : sbsi_pkg::TAP_CAP_IR;
			sbsi_pkg::TAP_CAP_IR: state_nxt = tms ? sbsi_pkg::TAP_EX1_IR : sbsi_pkg::TAP_SH_IR;
			sbsi_pkg::TAP_SH_IR: state_nxt = tms ? sbsi_pkg::TAP_EX1_IR : sbsi_pkg::TAP_SH_IR;
			sbsi_pkg::TAP_EX1_IR: state_nxt = tms ? sbsi_pkg::TAP_UP_IR : sbsi_pkg::TAP_PAU_IR;
			sbsi_pkg::TAP_PAU_IR: state_nxt = tms ? sbsi_pkg::TAP_EX2_IR : sbsi_pkg::TAP_PAU_IR;
			sbsi_pkg::TAP_EX2_IR: state_nxt = tms ? sbsi_pkg::TAP_UP_IR : sbsi_pkg::TAP_SH_IR;
			sbsi_pkg::TAP_UP_IR: state_nxt = tms ? sbsi_pkg::TAP_SEL_DR : sbsi_pkg::TAP_IDLE;
			default: state_nxt = sbsi_pkg::TAP_RESET;
		endcase
	end

	// State register, reset at power-up
	always_ff @(posedge tck or negedge rstN) begin
		if (!rstN) begin
			state_r <= sbsi_pkg::TAP_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign state = state_r;
endmodule // sbsi_tap_fsm
`default_nettype wire

//--- sim/sbsi_tb_ctl.sv
// Scan test controller model driving the link
`timescale 1ns/10ps
`default_nettype none
`include "sbsi_params.svh"
module sbsi_tb_ctl (
	// Link outputs
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	// Link inputs
	input wire logic tdo,
	input wire logic tdoEn
);
	// ****************
	// Link cycles
	// ****************
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One tck period, tdo read at the rise; tdo pulled up when not driven
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		#40;
		tck = 1'b1;
		q = tdoEn ? tdo : 1'b1;
		#40;
		tck = 1'b0;
	endtask

	// Clock stops; released lines float high
	task automatic release_link();
		tms <= 1'b1;
		tdi <= 1'b1;
		#40;
	endtask

	task automatic resetIdle();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		release_link();
	endtask

	task automatic loadIr(input logic [`SBSI_IR_W-1:0] code, output logic [`SBSI_IR_W-1:0] capt);
		logic q;
		step(1'b1, 1'b1, q);
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < `SBSI_IR_W; i++) begin
			step(i == `SBSI_IR_W - 1, code[i], capt[i]);
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		release_link();
	endtask

	// data scan of n bits, bit 0 first
	task automatic shiftDr(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i]);
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		release_link();
	endtask
endmodule // sbsi_tb_ctl
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench of the boundary-scan test port
`timescale 1ns/10ps
`default_nettype none
`include "sbsi_params.svh"
`define SBSI_CHK(act, exp, msg) begin nChecks++; if ((act) !== (exp)) begin badCount++; $display("[ERR] %0t %s", $time, msg); end end
module tb_top;
	// ****************
	// Signals
	// ****************
	logic sys_clk;
	logic arst_n;
	wire logic tck;
	wire logic tms;
	wire logic tdi;
	logic tdo;
	logic tdoEn;
	logic [`SBSI_NIN-1:0] ramInPins;
	logic [`SBSI_NOUT-1:0] funcQ;
	logic funcQEn;
	logic [`SBSI_NOUT-1:0] ramQ;
	logic ramQEn;
	int badCount;
	int nChecks;
	int cycles = 0;
	logic [`SBSI_IR_W-1:0] irCap;
	logic [31:0] dOut;

	sbsi_scan_top u_sbsi_scan_top (.sys_clk(sys_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdoEn(tdoEn), .ramInPins(ramInPins), .funcQ(funcQ), .funcQEn(funcQEn),
		.ramQ(ramQ), .ramQEn(ramQEn));
	sbsi_tb_ctl u_sbsi_tb_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));

	// ****************
	// Clock and timeout
	// ****************
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			badCount++;
			giveVerdict();
		end
	end

	// ****************
	// Helpers
	// ****************
	task automatic giveVerdict();
		if (badCount == 0 && nChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic setPins(input logic [7:0] p, input logic [3:0] q, input logic en);
		@(posedge sys_clk);
		ramInPins <= p;
		funcQ <= q;
		funcQEn <= en;
	endtask
	task automatic settle();
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic loadCode(input logic [`SBSI_IR_W-1:0] code);
		u_sbsi_tb_ctl.loadIr(code, irCap);
		`SBSI_CHK(irCap, `SBSI_IR_CAPTURE, "instruction capture pattern")
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic tIdcode();
		u_sbsi_tb_ctl.shiftDr(32, 32'h0000_0000, dOut);
		`SBSI_CHK(dOut, `SBSI_ID_CODE, "identification value")
	endtask
	task automatic tBypass();
		logic [2:0] codes [4] = '{`SBSI_IR_BYPASS, 3'h3, 3'h5, 3'h6};
		foreach (codes[i]) begin
			loadCode(codes[i]);
			u_sbsi_tb_ctl.shiftDr(9, 32'h0000_00a5, dOut);
			`SBSI_CHK(dOut[8:1], 8'ha5, "one-bit bypass path")
		end
	endtask
	task automatic tSample();
		setPins(8'h3c, 4'h9, 1'b1);
		loadCode(`SBSI_IR_SAMPLE);
		u_sbsi_tb_ctl.shiftDr(14, 32'h0000_0600, dOut);
		`SBSI_CHK(dOut[13:0], {`SBSI_FIX_VAL, 4'h9, 8'h3c}, "sample capture")
		settle();
		`SBSI_CHK(ramQ, 4'h9, "outputs stay functional")
	endtask
	task automatic tExtest();
		loadCode(`SBSI_IR_EXTEST);
		settle();
		`SBSI_CHK(ramQ, 4'h6, "preloaded cells on outputs")
		`SBSI_CHK(ramQEn, 1'b1, "outputs driven in extest")
		setPins(8'hc1, 4'h9, 1'b0);
		u_sbsi_tb_ctl.shiftDr(14, 32'h0000_0a00, dOut);
		`SBSI_CHK(dOut[13:0], {`SBSI_FIX_VAL, 4'h6, 8'hc1}, "extest capture")
		settle();
		`SBSI_CHK(ramQ, 4'ha, "updated cells on outputs")
		`SBSI_CHK(ramQEn, 1'b1, "enable ignores core in extest")
	endtask
	task automatic tSampleZ();
		setPins(8'h5a, 4'h3, 1'b1);
		loadCode(`SBSI_IR_SAMPLEZ);
		settle();
		`SBSI_CHK(ramQEn, 1'b0, "outputs floated")
		u_sbsi_tb_ctl.shiftDr(14, 32'h0000_0000, dOut);
		`SBSI_CHK({dOut[13:12], dOut[7:0]}, {`SBSI_FIX_VAL, 8'h5a}, "float capture")
	endtask
	task automatic tTmsReset();
		u_sbsi_tb_ctl.resetIdle();
		settle();
		`SBSI_CHK(ramQEn, 1'b1, "float left after reset")
		`SBSI_CHK(ramQ, 4'h3, "functional data after reset")
		tIdcode();
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		arst_n = 1'b0;
		ramInPins = 8'h00;
		funcQ = 4'h0;
		funcQEn = 1'b0;
		badCount = 0;
		nChecks = 0;
		#7;
		fork
			u_sbsi_tb_ctl.resetIdle();
			begin
				repeat (12) @(posedge sys_clk);
				arst_n <= 1'b1;
			end
		join
		u_sbsi_tb_ctl.resetIdle();
		tIdcode();
		tBypass();
		tSample();
		tExtest();
		tSampleZ();
		tTmsReset();
		giveVerdict();
	end
endmodule // tb_top
`undef SBSI_CHK
`default_nettype wire
